// ==== rtl/sdb_core.sv ====
// Purpose: Command decode, bank state and double-rate burst engine of the memory.
// Assumes: clk_sys is several times faster than the link clock; all pins are asynchronous.
// Notes:   Burst timing follows detected link clock and strobe edges, not clk_sys.
// Behaviour
// - Each access moves one eight-byte word as eight byte-wide half-cycle beats, or half of it as four beats when chopped.
// - Data pins carry two beats per link clock cycle, both directions.
// - On reads the memory drives data and strobe, data edge-aligned to strobe.
// - Command and address are sampled on true clock rising, complement falling.
// - First write beat is taken on first strobe rise after the preamble.
// - First read beat goes out on first strobe rise after the preamble.
// - Activate uses its own bank and address to open bank and row.
// - Read or write uses its bank and address for bank and start column.
// - Burst starts at the chosen column and follows the programmed order.
// - Eight-beat bursts and four-beat chopped bursts are both supported.
// - With auto precharge the row closes by itself when the burst ends.
// - Eight independent banks; bank commands proceed while another bank bursts.
// - Reads and writes come as mode length, forced chop four, forced eight.
// - Row address spans bits 14 to 0 on the byte-wide part.
// - Self refresh and a separate power-down mode are provided.
// - Precharge with address bit 10 low closes one bank, high closes all.
// - With on-the-fly chop, address bit 12 high gives eight beats, low four.
`timescale 1ns/1ns
`default_nettype none
module sdb_core (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  // Link clock
  input  wire logic                       ck_t,
  input  wire logic                       ck_c,
  input  wire logic                       cke,
  // Command and address
  input  wire logic                       cs_n,
  input  wire logic                       ras_n,
  input  wire logic                       cas_n,
  input  wire logic                       we_n,
  input  wire logic [sdb_pkg::BA_W-1:0]   ba,
  input  wire logic [sdb_pkg::ADDR_W-1:0] addr,
  // Data and strobe
  input  wire logic [sdb_pkg::DQ_W-1:0]   dq_in,
  output logic      [sdb_pkg::DQ_W-1:0]   dq_out,
  output logic                            dq_oe,
  input  wire logic                       dqs_t_in,
  input  wire logic                       dqs_c_in,
  output logic                            dqs_t_out,
  output logic                            dqs_c_out,
  output logic                            dqs_oe,
  // Static configuration
  input  wire logic [1:0]                 bl_mode,
  input  wire logic                       interleave,
  // Status
  output logic      [sdb_pkg::BANKS-1:0]  bank_open,
  output logic                            self_refresh,
  output logic                            power_down
);

  sdb_pkg::sdb_pins_t  raw;
  sdb_pkg::sdb_pins_t  p;
  sdb_pkg::sdb_state_t st;
  sdb_pkg::sdb_state_t next_st;
  sdb_pkg::sdb_cmd_t   cmd;
  logic [sdb_pkg::WORD_W-1:0] mem [sdb_pkg::MEM_DEPTH];
  logic                ck_pos;
  logic                ck_neg;
  logic                ck_edge;
  logic                dqs_rise;
  logic                dqs_edge;
  logic                cmd_ok;
  logic                acc_start;
  logic                chop_sel;
  logic [2:0]          last_beat;
  logic [sdb_pkg::COL_W-1:0] col;

  always_comb begin
    raw.ck_t       = ck_t;
    raw.ck_c       = ck_c;
    raw.cke        = cke;
    raw.cs_n       = cs_n;
    raw.ras_n      = ras_n;
    raw.cas_n      = cas_n;
    raw.we_n       = we_n;
    raw.ba         = ba;
    raw.addr       = addr;
    raw.dq         = dq_in;
    raw.dqs_t      = dqs_t_in;
    raw.dqs_c      = dqs_c_in;
    raw.bl_mode    = bl_mode;
    raw.interleave = interleave;
  end

  // Strobe and data share one synchroniser so they keep their relative timing.
  sdb_sync #(
    .W ($bits(sdb_pkg::sdb_pins_t))
  ) u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .d       (raw),
    .q       (p)
  );

  // Positive edge: true clock rises while the complement falls.
  assign ck_pos   = p.ck_t & ~st.ck_t & ~p.ck_c & st.ck_c;
  assign ck_neg   = ~p.ck_t & st.ck_t & p.ck_c & ~st.ck_c;
  assign ck_edge  = ck_pos | ck_neg;
  assign dqs_edge = (p.dqs_t != st.dqs_t) & (p.dqs_c != p.dqs_t);
  assign dqs_rise = dqs_edge & p.dqs_t;
  assign cmd      = p.cs_n ? sdb_pkg::CMD_NOP : sdb_pkg::sdb_cmd_t'({p.ras_n, p.cas_n, p.we_n});
  assign cmd_ok   = ck_pos & p.cke & st.cke & (st.pwr == sdb_pkg::P_ACTIVE);
  // An access to a closed bank is dropped; the controller must open it first.
  assign acc_start = cmd_ok & (st.xfer == sdb_pkg::X_IDLE) & st.bank_open[p.ba] &
                     ((cmd == sdb_pkg::CMD_RD) | (cmd == sdb_pkg::CMD_WR));
  assign chop_sel  = (p.bl_mode == sdb_pkg::BL_FIX4) |
                     ((p.bl_mode == sdb_pkg::BL_OTF) & ~p.addr[sdb_pkg::BC_BIT]);
  assign last_beat = st.chop ? sdb_pkg::LAST_BC4 : sdb_pkg::LAST_BL8;
  assign col       = sdb_pkg::sdb_beat_col(st.start, st.beat, st.il);

  always_comb begin
    logic [sdb_pkg::COL_W-1:0] ncol;
    ncol           = sdb_pkg::sdb_beat_col(st.start, 3'(st.beat + 3'h1), st.il);
    next_st        = st;
    next_st.mem_we = 1'b0;
    next_st.ck_t   = p.ck_t;
    next_st.ck_c   = p.ck_c;
    next_st.dqs_t  = p.dqs_t;
    if (ck_pos) begin
      next_st.cke = p.cke;
      unique case (st.pwr)
        sdb_pkg::P_ACTIVE: if (st.cke && !p.cke) begin
          next_st.pwr = (cmd == sdb_pkg::CMD_REF) ? sdb_pkg::P_SREF : sdb_pkg::P_PDOWN;
        end
        sdb_pkg::P_PDOWN,
        sdb_pkg::P_SREF: if (p.cke) begin
          next_st.pwr = sdb_pkg::P_ACTIVE;
        end
      endcase
    end
    // Bank commands act at once, even while another bank is bursting.
    if (cmd_ok && cmd == sdb_pkg::CMD_PRE) begin
      if (p.addr[sdb_pkg::AP_BIT]) begin
        next_st.bank_open = '0;
      end else begin
        next_st.bank_open[p.ba] = 1'b0;
      end
    end
    if (acc_start) begin
      next_st.bank  = p.ba;
      next_st.start = p.addr[sdb_pkg::COL_W-1:0];
      next_st.idx   = {p.ba, st.row[p.ba][0], p.addr[sdb_pkg::COL_HI:sdb_pkg::COL_LO]};
      next_st.ap    = p.addr[sdb_pkg::AP_BIT];
      next_st.chop  = chop_sel;
      next_st.il    = p.interleave;
      next_st.lat   = '0;
      next_st.beat  = '0;
      // A write starts from the stored word as well, so a chopped write keeps the other half.
      next_st.word  = mem[next_st.idx];
      if (cmd == sdb_pkg::CMD_RD) begin
        next_st.xfer = sdb_pkg::X_RLAT;
      end else begin
        next_st.xfer = sdb_pkg::X_WLAT;
      end
    end
    unique case (st.xfer)
      sdb_pkg::X_IDLE: begin
      end
      sdb_pkg::X_RLAT: if (ck_pos) begin
        if (st.lat == 4'(sdb_pkg::READ_LAT_CK - 2)) begin
          next_st.xfer    = sdb_pkg::X_RPRE;
          next_st.dqs_oe  = 1'b1;
          next_st.dqs_out = 1'b0;
        end else begin
          next_st.lat = 4'(st.lat + 4'h1);
        end
      end
      sdb_pkg::X_RPRE: if (ck_pos) begin
        next_st.xfer    = sdb_pkg::X_RDATA;
        next_st.dqs_out = 1'b1;
        next_st.dq_oe   = 1'b1;
        next_st.dq_out  = st.word[sdb_pkg::DQ_W * col +: sdb_pkg::DQ_W];
      end
      sdb_pkg::X_RDATA: if (ck_edge) begin
        if (st.beat == last_beat) begin
          next_st.xfer    = sdb_pkg::X_RPOST;
          next_st.dqs_out = 1'b0;
          next_st.dq_oe   = 1'b0;
        end else begin
          next_st.beat    = 3'(st.beat + 3'h1);
          next_st.dqs_out = ~st.dqs_out;
          next_st.dq_out  = st.word[sdb_pkg::DQ_W * ncol +: sdb_pkg::DQ_W];
        end
      end
      sdb_pkg::X_RPOST: if (ck_neg) begin
        next_st.xfer   = sdb_pkg::X_IDLE;
        next_st.dqs_oe = 1'b0;
        if (st.ap) begin
          next_st.bank_open[st.bank] = 1'b0;
        end
      end
      sdb_pkg::X_WLAT: if (ck_pos) begin
        if (st.lat == 4'(sdb_pkg::WRITE_LAT_CK - 2)) begin
          next_st.xfer = sdb_pkg::X_WDATA;
        end else begin
          next_st.lat = 4'(st.lat + 4'h1);
        end
      end
      // Strobe edges sit mid-eye, so the data sampled beside them is settled.
      sdb_pkg::X_WDATA: if (dqs_edge && (st.beat != 3'h0 || dqs_rise)) begin
        next_st.word[sdb_pkg::DQ_W * col +: sdb_pkg::DQ_W] = p.dq;
        if (st.beat == last_beat) begin
          next_st.xfer   = sdb_pkg::X_IDLE;
          next_st.mem_we = 1'b1;
          if (st.ap) begin
            next_st.bank_open[st.bank] = 1'b0;
          end
        end else begin
          next_st.beat = 3'(st.beat + 3'h1);
        end
      end
    endcase
    // Placed last so that an activate wins over an auto precharge of the same bank.
    if (cmd_ok && cmd == sdb_pkg::CMD_ACT) begin
      next_st.bank_open[p.ba] = 1'b1;
      next_st.row[p.ba]       = p.addr;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // A chopped write keeps the untouched half of the stored word.
  always_ff @(posedge clk_sys) begin
    if (st.mem_we) begin
      mem[st.idx] <= st.word;
    end
  end

  assign dq_out       = st.dq_out;
  assign dq_oe        = st.dq_oe;
  assign dqs_t_out    = st.dqs_out;
  assign dqs_c_out    = ~st.dqs_out;
  assign dqs_oe       = st.dqs_oe;
  assign bank_open    = st.bank_open;
  assign self_refresh = (st.pwr == sdb_pkg::P_SREF);
  assign power_down   = (st.pwr == sdb_pkg::P_PDOWN);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence act_s;
    cmd_ok && cmd == sdb_pkg::CMD_ACT;
  endsequence
  sequence pre_all_s;
    cmd_ok && cmd == sdb_pkg::CMD_PRE && p.addr[sdb_pkg::AP_BIT];
  endsequence
  sequence rd_start_s;
    acc_start && cmd == sdb_pkg::CMD_RD;
  endsequence

  ddr_halves_a: assert property ($changed(st.dqs_out) && st.xfer == sdb_pkg::X_RDATA |-> $past(ck_edge))
    else $error("read strobe moved without a link clock edge");
  edge_align_a: assert property ($changed(st.dq_out) && st.dq_oe |-> $changed(st.dqs_out))
    else $error("read data changed apart from a strobe edge");
  read_pre_a: assert property ($rose(st.xfer == sdb_pkg::X_RDATA)
    |-> $past(st.dqs_oe) && !$past(st.dqs_out) && st.dqs_out)
    else $error("first read beat not on first strobe rise after preamble");
  cmd_edge_a: assert property ($rose(st.xfer == sdb_pkg::X_RLAT) |-> $past(ck_pos))
    else $error("read taken away from a positive clock edge");
  act_open_a: assert property (act_s |=> st.bank_open[$past(p.ba)] && st.row[$past(p.ba)] == $past(p.addr))
    else $error("activate did not open the sampled bank and row");
  pre_all_a: assert property (pre_all_s |=> st.bank_open == '0)
    else $error("precharge all left a bank open");
  chop_otf_a: assert property (rd_start_s ##0 p.bl_mode == sdb_pkg::BL_OTF
    |=> st.chop == !$past(p.addr[sdb_pkg::BC_BIT]))
    else $error("on-the-fly chop did not follow address bit 12");
  read_lat_a: assert property (rd_start_s |=> st.xfer == sdb_pkg::X_RLAT ##[1:400] st.xfer == sdb_pkg::X_RPRE)
    else $error("read preamble did not follow the read command");
  burst_len_a: assert property ($fell(st.xfer == sdb_pkg::X_RDATA)
    |-> $past(st.beat) == ($past(st.chop) ? sdb_pkg::LAST_BC4 : sdb_pkg::LAST_BL8))
    else $error("read burst ended at the wrong beat count");
  wr_first_a: assert property ($past(st.xfer) == sdb_pkg::X_WDATA && $past(st.beat) == 3'h0
    && st.beat == 3'h1 |-> $past(dqs_rise))
    else $error("first write beat not taken on a strobe rise");
  auto_pre_a: assert property ($fell(st.xfer == sdb_pkg::X_RPOST) && $past(st.ap)
    |-> !st.bank_open[$past(st.bank)])
    else $error("auto precharge left the bank open");

endmodule
`default_nettype wire

// ==== rtl/sdb_pkg.sv ====
// Purpose: Shared constants, types and helpers for the burst access core.
// Assumes: Byte-wide part; clk_sys samples every pin, including the link clock.
// Notes:   The storage array is a small window onto the real address space.
package sdb_pkg;

  // Geometry.
  localparam int DQ_W        = 8;
  localparam int BANKS       = 8;
  localparam int BA_W        = 3;
  localparam int ROW_W       = 15;
  localparam int ADDR_W      = 15;
  localparam int BEATS       = 8;
  localparam int WORD_W      = DQ_W * BEATS;
  localparam int COL_W       = 3;
  localparam int MEM_AW      = 6;
  localparam int MEM_DEPTH   = 64;

  // Address fields.
  localparam int AP_BIT      = 10;
  localparam int BC_BIT      = 12;
  localparam int COL_HI      = 4;
  localparam int COL_LO      = 3;

  // Latencies in link clock cycles, command edge to first data edge.
  localparam int READ_LAT_CK  = 5;
  localparam int WRITE_LAT_CK = 5;

  localparam logic [2:0] LAST_BL8 = 3'h7;
  localparam logic [2:0] LAST_BC4 = 3'h3;

  // Burst length selection, as a static configuration input.
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;

  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR  = 3'h4,
    CMD_RD  = 3'h5,
    CMD_ZQ  = 3'h6,
    CMD_NOP = 3'h7
  } sdb_cmd_t;

  typedef enum logic [2:0] {X_IDLE, X_RLAT, X_RPRE, X_RDATA, X_RPOST, X_WLAT, X_WDATA} sdb_xfer_t;
  typedef enum logic [1:0] {P_ACTIVE, P_PDOWN, P_SREF} sdb_pwr_t;

  typedef struct packed {
    logic              ck_t;
    logic              ck_c;
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   dq;
    logic              dqs_t;
    logic              dqs_c;
    logic [1:0]        bl_mode;
    logic              interleave;
  } sdb_pins_t;

  typedef struct packed {
    logic                        ck_t;
    logic                        ck_c;
    logic                        dqs_t;
    logic                        cke;
    sdb_pwr_t                    pwr;
    logic [BANKS-1:0]            bank_open;
    logic [BANKS-1:0][ROW_W-1:0] row;
    sdb_xfer_t                   xfer;
    logic [3:0]                  lat;
    logic [2:0]                  beat;
    logic                        chop;
    logic                        ap;
    logic [BA_W-1:0]             bank;
    logic [COL_W-1:0]            start;
    logic                        il;
    logic [MEM_AW-1:0]           idx;
    logic [WORD_W-1:0]           word;
    logic [DQ_W-1:0]             dq_out;
    logic                        dqs_out;
    logic                        dq_oe;
    logic                        dqs_oe;
    logic                        mem_we;
  } sdb_state_t;

  // Column of beat i for a burst that starts at column start.
  function automatic logic [COL_W-1:0] sdb_beat_col(input logic [COL_W-1:0] start,
                                                     input logic [2:0]       i,
                                                     input logic             il);
    logic [1:0] low;
    low = 2'(start[1:0] + i[1:0]);
    return il ? (start ^ i) : {start[2] ^ i[2], low};
  endfunction

endpackage

// ==== rtl/sdb_sync.sv ====
// Purpose: Two-stage synchroniser for a bundle of pin levels.
// Assumes: Each bit is an independent level; no bus coherence is promised.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/1ns
`default_nettype none
module sdb_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule
`default_nettype wire

// ==== tb/sdb_ctl_model.sv ====
// Purpose: Memory controller model: link clock, commands and centred write bursts.
// Assumes: Link clock of 400 ns that runs freely, as a memory clock does.
// Notes:   Idle data and strobe toggle every link cycle, and bank and address take their complement after a command, so a stale value never passes.
`timescale 1ns/1ns
`default_nettype none
module sdb_ctl_model (
  // Link clock and command
  output logic            ck_t,
  output logic            ck_c,
  output logic            cke,
  output logic            cs_n,
  output logic            ras_n,
  output logic            cas_n,
  output logic            we_n,
  output logic [2:0]      ba,
  output logic [14:0]     addr,
  // Data and strobe
  output logic [7:0]      dq_drv,
  output logic            dqs_drv,
  input  wire logic [7:0] dq_w,
  input  wire logic       dqs_t_w,
  input  wire logic       dqs_c_w,
  input  wire logic       dq_oe,
  input  wire logic       dqs_oe
);
  int   pcnt  = 0;
  int   mark  = 0;
  logic wr_on = 1'b0;

  // Grades are numbered industrial, automotive, ultra-high from 0.
  localparam int ULTRA_HIGH_GRADE = 2;

  // Refresh commands owed per nominal refresh interval at a case temperature.
  function automatic int ref_per_interval(input int grade, input int temp_c);
    if (temp_c <= 85)
      return 1;
    if (grade != ULTRA_HIGH_GRADE || temp_c <= 105)
      return 2;
    return (temp_c <= 115) ? 4 : 8;
  endfunction

  function automatic logic sref_allowed(input int grade, input int temp_c);
    return (grade != ULTRA_HIGH_GRADE) || (temp_c <= 105);
  endfunction

  assign ck_c = ~ck_t;

  initial begin
    ck_t = 1'b0;
    cke = 1'b0;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = 3'h0;
    addr = 15'h0;
    dq_drv = 8'h0;
    dqs_drv = 1'b0;
    #10;
    forever #200 ck_t = ~ck_t;
  end

  always @(posedge ck_t) begin
    pcnt <= pcnt + 1;
    if (!wr_on) begin
      dq_drv <= ~dq_drv;
      dqs_drv <= ~dqs_drv;
    end
  end

  // Command and address stand a half link cycle either side of the rising edge.
  task automatic cmd(input sdb_pkg::sdb_cmd_t c, input logic [2:0] b, input logic [14:0] a, input logic k);
    @(negedge ck_t);
    cke <= k;
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
    @(posedge ck_t);
    mark = pcnt + 1;
    @(negedge ck_t);
    {ras_n, cas_n, we_n} <= 3'h7;
    ba <= ~b;
    addr <= ~a;
  endtask

  // Refresh with cke high; the core keeps no charge to restore and must ignore it.
  task automatic refresh(input int grade, input int temp_c);
    for (int i = 0; i < ref_per_interval(grade, temp_c); i++)
      cmd(sdb_pkg::CMD_REF, 3'h0, 15'h0, 1'b1);
  endtask

  // Each byte is set up a quarter cycle before its strobe edge, so the edge sits mid-eye.
  task automatic wr(input logic [2:0] b, input logic [14:0] a, input int n, input logic [63:0] d);
    cmd(sdb_pkg::CMD_WR, b, a, 1'b1);
    // Idle toggling stops one edge early, so the preamble is the only strobe drive at its edge.
    wait (pcnt == mark + 3);
    wr_on = 1'b1;
    @(posedge ck_t);
    dqs_drv <= 1'b0;
    #300;
    for (int i = 0; i < n; i++) begin
      dq_drv <= d[8*i +: 8];
      #100;
      dqs_drv <= ~dqs_drv;
      #100;
    end
    wr_on = 1'b0;
  endtask

  task automatic rd(input logic [2:0] b, input logic [14:0] a, input int n,
                    output logic [63:0] q, output int lat, output logic ok);
    q = '0;
    cmd(sdb_pkg::CMD_RD, b, a, 1'b1);
    for (int k = 0; k < 400 && dq_oe !== 1'b1; k++)
      #5;
    #2;
    lat = pcnt - mark;
    ok = dqs_oe & dqs_t_w & ~dqs_c_w;
    q[7:0] = dq_w;
    for (int i = 1; i < n; i++) begin
      @(dqs_t_w);
      #2;
      q[8*i +: 8] = dq_w;
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the burst core against a byte-wise memory model.
// Assumes: Byte-wide part, 20 MHz system clock, controller model owns the link clock.
// Notes:   Each word is first filled by an eight-beat write, so reads see no unwritten byte.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic             clk_sys;
  logic             resetn;
  logic [1:0]       bl_mode;
  logic             interleave;
  wire logic        ck_t, ck_c, cke, cs_n, ras_n, cas_n, we_n;
  wire logic [2:0]  ba;
  wire logic [14:0] addr;
  wire logic [7:0]  dq_drv, dq_out, dq_w, bank_open;
  wire logic        dqs_drv, dq_oe, dqs_t_out, dqs_c_out, dqs_oe, dqs_t_w, dqs_c_w;
  wire logic        self_refresh, power_down;
  int               num_errors = 0;
  int               checks_done = 0;
  int               cyc = 0;
  int               orow [8];
  logic [7:0]       exp_open = 8'h0;
  logic [7:0]       mem [int];
  logic [31:0]      seed = 32'h51f3b8f0;

  // Only the lower byte lane exists; a wide part used half-width keeps its data on this lane.
  assign dq_w = dq_oe ? dq_out : dq_drv;
  assign dqs_t_w = dqs_oe ? dqs_t_out : dqs_drv;
  assign dqs_c_w = dqs_oe ? dqs_c_out : ~dqs_drv;

  sdb_ctl_model i_ctl (
    .ck_t(ck_t), .ck_c(ck_c), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr), .dq_drv(dq_drv), .dqs_drv(dqs_drv), .dq_w(dq_w), .dqs_t_w(dqs_t_w),
    .dqs_c_w(dqs_c_w), .dq_oe(dq_oe), .dqs_oe(dqs_oe)
  );

  sdb_core i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .ck_t(ck_t), .ck_c(ck_c), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_w), .dq_out(dq_out),
    .dq_oe(dq_oe), .dqs_t_in(dqs_t_w), .dqs_c_in(dqs_c_w), .dqs_t_out(dqs_t_out), .dqs_c_out(dqs_c_out),
    .dqs_oe(dqs_oe), .bl_mode(bl_mode), .interleave(interleave), .bank_open(bank_open),
    .self_refresh(self_refresh), .power_down(power_down)
  );

  task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int lane(int s, int i);
    if (interleave)
      return s ^ i;
    return ((s ^ i) & 4) | ((s + i) & 3);
  endfunction

  function automatic int key(int b, logic [14:0] a, int ln);
    return ((b * 2 + (orow[b] & 1)) * 4 + int'(a[4:3])) * 8 + ln;
  endfunction

  function automatic int nb(logic [14:0] a);
    if (bl_mode == 2'h2 || (bl_mode == 2'h1 && !a[12]))
      return 4;
    return 8;
  endfunction

  function automatic logic [14:0] mk(logic [1:0] w, logic ap, logic bc);
    logic [14:0] a;
    a = 15'(xs());
    a[12] = bc;
    a[10] = ap;
    a[4:3] = w;
    return a;
  endfunction

  task automatic setcfg(logic il, logic [1:0] m);
    @(posedge clk_sys);
    interleave <= il;
    bl_mode <= m;
    @(posedge clk_sys);
  endtask

  task automatic chk_open();
    repeat (2) @(posedge ck_t);
    check("bank open", 64'(bank_open), 64'(exp_open));
  endtask

  task automatic pre(int b, logic all);
    i_ctl.cmd(sdb_pkg::CMD_PRE, 3'(b), 15'(all) << 10, 1'b1);
    if (all)
      exp_open = 8'h0;
    else
      exp_open[b] = 1'b0;
    chk_open();
  endtask

  task automatic wr_op(int b, logic [14:0] a);
    int n;
    logic [63:0] d;
    n = nb(a);
    d = {xs(), xs()};
    i_ctl.wr(3'(b), a, n, d);
    for (int i = 0; i < n; i++)
      mem[key(b, a, lane(a[2:0], i))] = d[8*i +: 8];
  endtask

  task automatic rd_op(int b, logic [14:0] a);
    int n;
    int lat;
    logic ok;
    logic [63:0] q;
    logic [63:0] e;
    n = nb(a);
    e = '0;
    for (int i = 0; i < n; i++)
      e[8*i +: 8] = mem[key(b, a, lane(a[2:0], i))];
    i_ctl.rd(3'(b), a, n, q, lat, ok);
    check("read word", q, e);
    check("read latency", 64'(lat), 64'(sdb_pkg::READ_LAT_CK));
    check("strobe at first beat", 64'(ok), 64'h1);
    if (a[10])
      exp_open[b] = 1'b0;
    chk_open();
  endtask

  // Full write, then a partial or full overwrite, then a read, in every bank at a random start column.
  task automatic t_burst(logic il, logic [1:0] mp, logic bp, logic [1:0] mr, logic br);
    for (int s = 0; s < 8; s++) begin
      pre(s, 1'b0);
      orow[s] = int'(xs() & 32'h7fff);
      i_ctl.cmd(sdb_pkg::CMD_ACT, 3'(s), 15'(orow[s]), 1'b1);
      exp_open[s] = 1'b1;
      chk_open();
      setcfg(il, 2'h0);
      wr_op(s, mk(2'(s), 1'b0, 1'b1));
      setcfg(il, mp);
      wr_op(s, mk(2'(s), 1'b0, bp));
      setcfg(il, mr);
      rd_op(s, mk(2'(s), s[0], br));
    end
    $display("burst test order %0d modes %0d %0d done", il, mp, mr);
  endtask

  task automatic pwr(sdb_pkg::sdb_cmd_t c, logic k, logic sr, logic pd);
    i_ctl.cmd(c, 3'h0, 15'h0, k);
    repeat (3) @(posedge ck_t);
    check("self refresh", 64'(self_refresh), 64'(sr));
    check("power down", 64'(power_down), 64'(pd));
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // The tests need about 10000 cycles; the ceiling leaves ample margin.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    logic hit;
    int   tc;
    resetn = 1'b0;
    bl_mode = 2'h0;
    interleave = 1'b0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    pwr(sdb_pkg::CMD_NOP, 1'b1, 1'b0, 1'b0);
    t_burst(1'b0, 2'h0, 1'b1, 2'h0, 1'b1);
    t_burst(1'b1, 2'h1, 1'b0, 2'h1, 1'b1);
    t_burst(1'b0, 2'h2, 1'b1, 2'h1, 1'b0);
    t_burst(1'b1, 2'h1, 1'b1, 2'h2, 1'b1);
    pre(0, 1'b1);
    i_ctl.cmd(sdb_pkg::CMD_RD, 3'h1, 15'h0, 1'b1);
    hit = 1'b0;
    repeat (8) begin
      @(posedge ck_t);
      if (dq_oe !== 1'b0)
        hit = 1'b1;
    end
    check("closed bank read", 64'(hit), 64'h0);
    $display("closed bank test done");
    tc = 80 + int'(xs() % 32'd46);
    for (int g = 0; g < 3; g++)
      i_ctl.refresh(g, tc);
    chk_open();
    pwr(sdb_pkg::CMD_NOP, 1'b1, 1'b0, 1'b0);
    // The ultra-high grade must cool down before it may enter self refresh.
    while (!i_ctl.sref_allowed(2, tc))
      tc = tc - 5;
    pwr(sdb_pkg::CMD_REF, 1'b0, 1'b1, 1'b0);
    pwr(sdb_pkg::CMD_NOP, 1'b1, 1'b0, 1'b0);
    pwr(sdb_pkg::CMD_NOP, 1'b0, 1'b0, 1'b1);
    pwr(sdb_pkg::CMD_NOP, 1'b1, 1'b0, 1'b0);
    $display("power test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
